/* File: design/ssx_alu.v */
// subtract, swap, xor and direction-load datapath
`timescale 1ns/1ns
`include "ssx_defines.vh"
module ssx_alu #(
  parameter WIDTH = 8
) (
  input  wire             CORE_CLK,
  input  wire             RST_B,
  input  wire             OP_VALID,
  input  wire [2:0]       OP_CODE,
  input  wire [WIDTH-1:0] OP_LIT,
  input  wire [6:0]       OP_ADDR,
  input  wire             OP_DEST,
  input  wire [WIDTH-1:0] FILE_RDATA,
  input  wire             CARRY_IN,
  input  wire             HALF_CARRY_IN,
  input  wire             ZERO_IN,
  output reg  [WIDTH-1:0] W_OUT,
  output reg              FILE_WE,
  output reg  [6:0]       FILE_WADDR,
  output reg  [WIDTH-1:0] FILE_WDATA,
  output reg              FLAG_WE,
  output reg              CARRY_OUT,
  output reg              HALF_CARRY_OUT,
  output reg              ZERO_OUT,
  output reg  [WIDTH-1:0] PORT_A_DIRECTION,
  output reg  [WIDTH-1:0] PORT_B_DIRECTION,
  output reg  [WIDTH-1:0] PORT_C_DIRECTION
);
  // opcode view, each gated by valid
  wire             op_sublit;
  wire             op_subfile;
  wire             op_subbrw;
  wire             op_swap;
  wire             op_dirld;
  wire             op_xorimm;
  wire             op_xorfile;
  wire             op_sub_any;
  wire             op_xor_any;
  wire             op_routed;
  wire             dest_is_file;
  wire             dest_is_w;
  wire [2:0]       dir_sel;
  reg  [WIDTH-1:0] minu;
  reg              brw;
  reg  [WIDTH:0]   diff;
  reg  [4:0]       ldiff;
  reg              c_new;
  reg              dc_new;
  reg  [WIDTH-1:0] sub_res;
  reg  [WIDTH-1:0] swap_res;
  reg  [WIDTH-1:0] xor_res;
  reg  [WIDTH-1:0] res;
  reg              to_file;
  reg              to_w;
  reg              upd_c;
  reg              upd_z;
  reg              res_zero;
  reg              carry_d;
  reg              half_carry_d;
  reg              zero_d;
  reg  [WIDTH-1:0] w_d;

  assign op_sublit    = OP_VALID & (OP_CODE == `SSX_OP_SUBLIT);
  assign op_subfile   = OP_VALID & (OP_CODE == `SSX_OP_SUBFILE);
  assign op_subbrw    = OP_VALID & (OP_CODE == `SSX_OP_SUBBRW);
  assign op_swap      = OP_VALID & (OP_CODE == `SSX_OP_SWAP);
  assign op_dirld     = OP_VALID & (OP_CODE == `SSX_OP_DIRLD);
  assign op_xorimm    = OP_VALID & (OP_CODE == `SSX_OP_XORIMM);
  assign op_xorfile   = OP_VALID & (OP_CODE == `SSX_OP_XORFILE);
  assign op_sub_any   = op_sublit | op_subfile | op_subbrw;
  assign op_xor_any   = op_xorimm | op_xorfile;
  assign op_routed    = op_subfile | op_subbrw | op_swap | op_xorfile;
  assign dest_is_file = (OP_DEST == `SSX_DEST_F);
  assign dest_is_w    = (OP_DEST == `SSX_DEST_W);
  // only low operand bits pick a direction; aliases above 7 are not trapped
  assign dir_sel      = OP_ADDR[2:0];

  always @* begin
    minu = FILE_RDATA;
    if (op_sublit) begin
      minu = OP_LIT;
    end
  end

  always @* begin
    brw = 1'b0;
    if (op_subbrw) begin
      brw = ~CARRY_IN;
    end
  end

  always @* begin
    diff    = {1'b0, minu} - {1'b0, W_OUT} - {{WIDTH{1'b0}}, brw};
    ldiff   = {1'b0, minu[3:0]} - {1'b0, W_OUT[3:0]} - {4'h0, brw};
    sub_res = diff[WIDTH-1:0];
  end

  always @* begin
    c_new  = ~diff[WIDTH];
    dc_new = ~ldiff[4];
  end

  always @* begin
    swap_res = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
  end

  always @* begin
    xor_res = W_OUT ^ FILE_RDATA;
    if (op_xorimm) begin
      xor_res = W_OUT ^ OP_LIT;
    end
  end

  // result select by opcode
  always @* begin
    res = {WIDTH{1'b0}};
    case (OP_CODE)
      `SSX_OP_SUBLIT: begin
        res = sub_res;
      end
      `SSX_OP_SUBFILE: begin
        res = sub_res;
      end
      `SSX_OP_SUBBRW: begin
        res = sub_res;
      end
      `SSX_OP_SWAP: begin
        res = swap_res;
      end
      `SSX_OP_XORIMM: begin
        res = xor_res;
      end
      `SSX_OP_XORFILE: begin
        res = xor_res;
      end
      default: begin
        res = {WIDTH{1'b0}};
      end
    endcase
  end

  always @* begin
    to_file = 1'b0;
    to_w    = 1'b0;
    if (op_sublit | op_xorimm) begin
      to_w = 1'b1;
    end
    if (op_routed) begin
      to_file = dest_is_file;
      to_w    = dest_is_w;
    end
  end

  // flags touched per operation
  always @* begin
    upd_c = op_sub_any;
    upd_z = op_sub_any | op_xor_any;
  end

  always @* begin
    res_zero = (res == {WIDTH{1'b0}});
  end

  // on a valid op unaffected flags copy the incoming status; idle cycles hold the registered flags
  always @* begin
    carry_d      = CARRY_OUT;
    half_carry_d = HALF_CARRY_OUT;
    zero_d       = ZERO_OUT;
    if (OP_VALID) begin
      carry_d      = CARRY_IN;
      half_carry_d = HALF_CARRY_IN;
      zero_d       = ZERO_IN;
      if (upd_c) begin
        carry_d      = c_new;
        half_carry_d = dc_new;
      end
      if (upd_z) begin
        zero_d = res_zero;
      end
    end
  end

  // next working register value
  always @* begin
    w_d = W_OUT;
    if (to_w) begin
      w_d = res;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      W_OUT <= `SSX_W_RST;
    end else begin
      W_OUT <= w_d;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WE <= 1'b0;
    end else begin
      FILE_WE <= to_file;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WADDR <= 7'h00;
    end else begin
      FILE_WADDR <= OP_ADDR & `SSX_ADDR_MAX;
    end
  end

  // data follows every cycle; only the strobe qualifies it
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_WDATA <= `SSX_W_RST;
    end else begin
      FILE_WDATA <= res;
    end
  end

  // flag write strobe, one cycle
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FLAG_WE <= 1'b0;
    end else begin
      FLAG_WE <= upd_c | upd_z;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CARRY_OUT <= 1'b0;
    end else begin
      CARRY_OUT <= carry_d;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HALF_CARRY_OUT <= 1'b0;
    end else begin
      HALF_CARRY_OUT <= half_carry_d;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ZERO_OUT <= 1'b0;
    end else begin
      ZERO_OUT <= zero_d;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_A_DIRECTION <= `SSX_DIR_RST;
    end else if (op_dirld && dir_sel == `SSX_DIR_A) begin
      PORT_A_DIRECTION <= W_OUT;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_B_DIRECTION <= `SSX_DIR_RST;
    end else if (op_dirld && dir_sel == `SSX_DIR_B) begin
      PORT_B_DIRECTION <= W_OUT;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PORT_C_DIRECTION <= `SSX_DIR_RST;
    end else if (op_dirld && dir_sel == `SSX_DIR_C) begin
      PORT_C_DIRECTION <= W_OUT;
    end
  end

endmodule // ssx_alu

/* File: design/ssx_defines.vh */
// constants for the subtract/swap/xor datapath
// Functional notes
// - literal minus working register into working register
// - literal subtract carry and half carry rules
// - file minus working register, address to 127
// - file subtract carry and half carry rules
// - destination 0 working, 1 file register
// - swap destination follows the destination bit like the file ops
// - borrow subtract: file minus W minus borrow
// - swap nibbles, flags untouched
// - direction load: 5 A, 6 B, 7 C
// - xor immediate into working, zero only
// - xor file routed by destination, zero only
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH
`define SSX_OP_NONE    3'h0
`define SSX_OP_SUBLIT  3'h1
`define SSX_OP_SUBFILE 3'h2
`define SSX_OP_SUBBRW  3'h3
`define SSX_OP_SWAP    3'h4
`define SSX_OP_DIRLD   3'h5
`define SSX_OP_XORIMM  3'h6
`define SSX_OP_XORFILE 3'h7
`define SSX_DIR_A      3'h5
`define SSX_DIR_B      3'h6
`define SSX_DIR_C      3'h7
`define SSX_DEST_W     1'h0
`define SSX_DEST_F     1'h1
`define SSX_W_RST      8'h00
`define SSX_DIR_RST    8'hFF
`define SSX_ADDR_MAX   7'h7F
`endif

/* File: testbench/ssx_alu_sva.sv */
// assertions on the ssx datapath ports
`timescale 1ns/1ns
module ssx_alu_sva (
  input wire       CORE_CLK, RST_B, OP_VALID, OP_DEST, CARRY_IN, FILE_WE, FLAG_WE, CARRY_OUT, ZERO_OUT,
  input wire [2:0] OP_CODE,
  input wire [6:0] OP_ADDR,
  input wire [7:0] OP_LIT, FILE_RDATA, W_OUT, FILE_WDATA, PORT_B_DIRECTION
);
  // idle cycles read as code 0, which does nothing
  wire [2:0] c = OP_VALID ? OP_CODE : 3'h0;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  property p_sl; c == 3'h1 |=> W_OUT == $past(OP_LIT) - $past(W_OUT); endproperty
  a_sl: assert property (p_sl) else $error("literal subtract wrong");
  property p_slc; c == 3'h1 |=> CARRY_OUT == ($past(W_OUT) <= $past(OP_LIT)); endproperty
  a_slc: assert property (p_slc) else $error("literal carry wrong");
  property p_sf; c == 3'h2 && !OP_DEST |=> W_OUT == $past(FILE_RDATA) - $past(W_OUT); endproperty
  a_sf: assert property (p_sf) else $error("file subtract wrong");
  property p_fd; c == 3'h2 && OP_DEST |=> FILE_WE && W_OUT == $past(W_OUT); endproperty
  a_fd: assert property (p_fd) else $error("file destination wrong");
  property p_sw; c == 3'h4 |=> !FLAG_WE && CARRY_OUT == $past(CARRY_IN); endproperty
  a_sw: assert property (p_sw) else $error("swap touched flags");
  property p_dl; c == 3'h5 && OP_ADDR[2:0] == 3'h6 |=> PORT_B_DIRECTION == $past(W_OUT); endproperty
  a_dl: assert property (p_dl) else $error("direction load wrong");
  property p_xi; c == 3'h6 |=> W_OUT == ($past(W_OUT) ^ $past(OP_LIT)); endproperty
  a_xi: assert property (p_xi) else $error("xor immediate wrong");
  property p_z; FLAG_WE |-> ZERO_OUT == ((FILE_WE ? FILE_WDATA : W_OUT) == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag wrong");
  c_brw: cover property (c == 3'h3);
  c_swp: cover property (c == 3'h4);
  c_xf: cover property (c == 3'h7);
endmodule // ssx_alu_sva
bind ssx_alu ssx_alu_sva chk (.*);

/* File: testbench/ssx_core_model.sv */
// register file and status flags beside the ssx datapath
`timescale 1ns/1ns
module ssx_core_model (
  input  wire       CORE_CLK, FILE_WE, FLAG_WE, CARRY_OUT, HALF_CARRY_OUT, ZERO_OUT,
  input  wire [6:0] OP_ADDR, FILE_WADDR,
  input  wire [7:0] FILE_WDATA,
  output wire [7:0] FILE_RDATA,
  output reg        CARRY_IN = 1'b0, HALF_CARRY_IN = 1'b0, ZERO_IN = 1'b0
);
  reg [7:0] mem_q [0:127];
  // unwritten places read unknown, so stray reads show up
  assign FILE_RDATA = mem_q[OP_ADDR];
  always @(posedge CORE_CLK) begin
    if (FILE_WE) mem_q[FILE_WADDR] <= FILE_WDATA;
    if (FLAG_WE) {CARRY_IN, HALF_CARRY_IN, ZERO_IN} <= {CARRY_OUT, HALF_CARRY_OUT, ZERO_OUT};
  end
endmodule // ssx_core_model

/* File: testbench/testbench.sv */
// self-checking bench for the ssx datapath
`timescale 1ns/1ns
module testbench;
  reg        CORE_CLK = 1'b0, RST_B = 1'b0, OP_VALID = 1'b0, OP_DEST = 1'b0;
  reg  [2:0] OP_CODE = 3'h0;
  reg  [7:0] OP_LIT = 8'h00;
  reg  [6:0] OP_ADDR = 7'h00;
  wire [7:0] W_OUT, FILE_WDATA, FILE_RDATA, PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_C_DIRECTION;
  wire [6:0] FILE_WADDR;
  wire       FILE_WE, FLAG_WE, CARRY_OUT, HALF_CARRY_OUT, ZERO_OUT, CARRY_IN, HALF_CARRY_IN, ZERO_IN;
  integer    error_cnt = 0, samples_checked = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  ssx_alu uut (.*);
  ssx_core_model fm (.*);
  task chk(input [23:0] s, input [23:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // address follows the immediate, so direction selects ride in it
  task op(input [2:0] c, input [7:0] k, input d, input [12:0] e);
    @(posedge CORE_CLK) {OP_VALID, OP_CODE, OP_LIT, OP_ADDR, OP_DEST} <= {1'b1, c, k, k[6:0], d};
    @(posedge CORE_CLK) OP_VALID <= 1'b0;
    #1 chk({11'h000, FILE_WE, FLAG_WE, CARRY_OUT, HALF_CARRY_OUT, ZERO_OUT, W_OUT}, {11'h000, e});
    $display("test op %0h done", c);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    fm.mem_q[127] = 8'h05;
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    chk({8'h00, PORT_A_DIRECTION, W_OUT}, 24'h00FF00);
    op(3'h6, 8'h18, 1'b0, 13'h0818);
    op(3'h1, 8'h21, 1'b0, 13'h0C09);
    op(3'h2, 8'h7F, 1'b1, 13'h1809);
    op(3'h3, 8'h7F, 1'b0, 13'h0EF2);
    op(3'h1, 8'hF2, 1'b0, 13'h0F00);
    op(3'h4, 8'h7F, 1'b1, 13'h1700);
    chk({1'b0, FILE_WADDR, 8'h00, FILE_WDATA}, 24'h7F00CF);
    op(3'h7, 8'h7F, 1'b0, 13'h0ECF);
    op(3'h5, 8'h06, 1'b0, 13'h06CF);
    chk({PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_C_DIRECTION}, 24'hFFCFFF);
    op(3'h2, 8'h7F, 1'b0, 13'h0F00);
    wrap_up;
  end
endmodule // testbench
